// [rtl/adcsc_pkg.sv]
/*
  Constants, register map and state type for the converter sequence control block.
  Assumes a 32-bit APB slave with byte addresses on word boundaries.
*/
`default_nettype none

package adcsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_SAMPLE_ACTIVE_FLAG_TIME = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Control one fields
  localparam int POS_ON = 15;
  localparam int POS_TRIG_LO = 5;
  localparam int POS_AUTO_SAMPLE_ACTIVE_FLAG = 2;
  localparam int POS_SAMPLE_ACTIVE_FLAG = 1;
  localparam int POS_DONE = 0;

  // Control two fields
  localparam int POS_REF_LO = 13;
  localparam int POS_OFFSET_CAL_ENABLE = 12;
  localparam int POS_SCAN = 10;
  localparam int POS_FILL_HALF = 7;
  localparam int POS_SEQ_LO = 2;
  localparam int POS_SPLIT = 1;
  localparam int POS_ALT = 0;

  // Interrupt status and mask bits
  localparam int POS_IRQ_SEQ = 0;
  localparam int POS_IRQ_CONV = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source codes
  localparam logic [2:0] TRIG_SOFT = 3'h0;
  localparam logic [2:0] TRIG_EXT_PIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_CHARGE = 3'h3;
  localparam logic [2:0] TRIG_AUTO = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_CTRL_ONE = 32'h00000000;
  localparam logic [31:0] RST_CTRL_TWO = 32'h00000000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [7:0] RST_SAMPLE_ACTIVE_FLAG_TIME = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states, Gray coded along idle, sample, convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } adcsc_state_t;

endpackage : adcsc_pkg

`default_nettype wire

// [rtl/adcsc_top.sv]
/*
  Sequence control of the analog-to-digital converter: trigger selection, sample and
  done flags, reference and input selection, sequence counting, buffer fill addressing.
  Assumes an APB master on core_clk, triggers from same-clock logic except the external
  interrupt pin, and a converter that pulses convComplete once per conversion.
*/
// The address map and the APB interface to the registers are this design's own decisions.
`default_nettype none

module adcsc_top
  import adcsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources
  input wire logic chargeTimeTrig,
  input wire logic timerThreeMatch,
  input wire logic extIntZeroPin,
  // Converter side
  input wire logic convComplete,
  output logic convStart,
  output logic sampling,
  output logic refHighExt,
  output logic refLowExt,
  output logic offsetCalOn,
  output logic scanOn,
  output logic muxSelB,
  // Result buffer addressing
  output logic bufWrEn,
  output logic [3:0] bufWrAddr,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  adcsc_state_t state_r, state_nxt;
  logic onBit_r;
  logic [2:0] trigSrc_r;
  logic autoSample_r;
  logic doneFlag_r, doneFlag_nxt;
  logic [2:0] refSel_r;
  logic offset_cal_enable_r;
  logic scanEn_r;
  logic [3:0] seqPerIrq_r;
  logic splitMode_r;
  logic altMode_r;
  logic fillHalf_r;
  logic [1:0] irqStat_r, irqStat_nxt;
  logic [1:0] irqMask_r;
  logic [7:0] sampTime_r;
  logic [7:0] sampCnt_r;
  logic [3:0] seqCnt_r;
  logic [3:0] wrIdx_r;
  logic altB_r;
  logic extSync1_r, extSync2_r, extPrev_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, convStart_r, sampling_r;
  logic refHighExt_r, refLowExt_r, offsetCalOn_r, scanOn_r, muxSelB_r;
  logic bufWrEn_r, irq_r;
  logic [3:0] bufWrAddr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire logic setupPhase = psel & ~penable;
  wire logic wrAccess = psel & penable & pwrite & pready_r;
  wire logic hitCtrlOne = (paddr == OFS_CTRL_ONE);
  wire logic hitCtrlTwo = (paddr == OFS_CTRL_TWO);
  wire logic hitIrqStat = (paddr == OFS_IRQ_STAT);
  wire logic hitIrqMask = (paddr == OFS_IRQ_MASK);
  wire logic hitSampTime = (paddr == OFS_SAMPLE_ACTIVE_FLAG_TIME);
  wire logic hitAny = hitCtrlOne | hitCtrlTwo | hitIrqStat | hitIrqMask | hitSampTime;
  wire logic wrCtrlOne = wrAccess & hitCtrlOne;
  wire logic wrCtrlTwo = wrAccess & hitCtrlTwo;
  wire logic wrIrqStat = wrAccess & hitIrqStat;
  wire logic wrIrqMask = wrAccess & hitIrqMask;
  wire logic wrSampTime = wrAccess & hitSampTime;

  wire logic sampleFlag = (state_r == ST_SAMPLE);

  wire logic [31:0] ctrlOneWord = {16'h0000, onBit_r, 7'h00, trigSrc_r, 2'h0,
                                   autoSample_r, sampleFlag, doneFlag_r};
  wire logic [31:0] ctrlTwoWord = {16'h0000, refSel_r, offset_cal_enable_r, 1'b0, scanEn_r, 2'h0,
                                   fillHalf_r, 1'b0, seqPerIrq_r, splitMode_r, altMode_r};
  wire logic [31:0] readMux = hitCtrlOne ? ctrlOneWord :
                              hitCtrlTwo ? ctrlTwoWord :
                              hitIrqStat ? {30'h0, irqStat_r} :
                              hitIrqMask ? {30'h0, irqMask_r} :
                              hitSampTime ? {24'h0, sampTime_r} : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setupPhase;
      pslverr_r <= setupPhase & ~hitAny;
      if (setupPhase) begin
        prdata_r <= readMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software controlled fields

  always_ff @(posedge core_clk) begin
    if (reset) begin
      onBit_r <= RST_CTRL_ONE[POS_ON];
      trigSrc_r <= RST_CTRL_ONE[POS_TRIG_LO +: 3];
      autoSample_r <= RST_CTRL_ONE[POS_AUTO_SAMPLE_ACTIVE_FLAG];
      refSel_r <= RST_CTRL_TWO[POS_REF_LO +: 3];
      offset_cal_enable_r <= RST_CTRL_TWO[POS_OFFSET_CAL_ENABLE];
      scanEn_r <= RST_CTRL_TWO[POS_SCAN];
      seqPerIrq_r <= RST_CTRL_TWO[POS_SEQ_LO +: 4];
      splitMode_r <= RST_CTRL_TWO[POS_SPLIT];
      altMode_r <= RST_CTRL_TWO[POS_ALT];
      irqMask_r <= RST_IRQ;
      sampTime_r <= RST_SAMPLE_ACTIVE_FLAG_TIME;
    end else begin
      if (wrCtrlOne) begin
        onBit_r <= pwdata[POS_ON];
        trigSrc_r <= pwdata[POS_TRIG_LO +: 3];
        autoSample_r <= pwdata[POS_AUTO_SAMPLE_ACTIVE_FLAG];
      end
      if (wrCtrlTwo) begin
        refSel_r <= pwdata[POS_REF_LO +: 3];
        offset_cal_enable_r <= pwdata[POS_OFFSET_CAL_ENABLE];
        scanEn_r <= pwdata[POS_SCAN];
        seqPerIrq_r <= pwdata[POS_SEQ_LO +: 4];
        splitMode_r <= pwdata[POS_SPLIT];
        altMode_r <= pwdata[POS_ALT];
      end
      if (wrIrqMask) begin
        irqMask_r <= pwdata[1:0];
      end
      if (wrSampTime) begin
        sampTime_r <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External pin synchroniser and edge detect

  always_ff @(posedge core_clk) begin
    if (reset) begin
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extPrev_r <= 1'b0;
    end else begin
      extSync1_r <= extIntZeroPin;
      extSync2_r <= extSync1_r;
      extPrev_r <= extSync2_r;
    end
  end

  wire logic extRise = extSync2_r & ~extPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection and sequencer

  wire logic autoDue = (sampCnt_r == sampTime_r);
  wire logic hwTrig = ((trigSrc_r == TRIG_AUTO) & autoDue) |
                      ((trigSrc_r == TRIG_CHARGE) & chargeTimeTrig) |
                      ((trigSrc_r == TRIG_TIMER) & timerThreeMatch) |
                      ((trigSrc_r == TRIG_EXT_PIN) & extRise);
  wire logic swConv = (trigSrc_r == TRIG_SOFT) & wrCtrlOne & ~pwdata[POS_SAMPLE_ACTIVE_FLAG];
  wire logic startConv = onBit_r & sampleFlag & (hwTrig | swConv);
  wire logic swSample = wrCtrlOne & pwdata[POS_SAMPLE_ACTIVE_FLAG] & ~autoSample_r;
  wire logic doneSet = onBit_r & (state_r == ST_CONVERT) & convComplete;
  wire logic seqHit = (seqCnt_r == seqPerIrq_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (onBit_r & (swSample | autoSample_r)) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (~onBit_r) begin
          state_nxt = ST_IDLE;
        end else if (startConv) begin
          state_nxt = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (~onBit_r) begin
          state_nxt = ST_IDLE;
        end else if (convComplete) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    doneFlag_nxt = doneFlag_r;
    if (doneSet) begin
      doneFlag_nxt = 1'b1;
    end else if (startConv) begin
      doneFlag_nxt = 1'b0;
    end else if (wrCtrlOne & ~pwdata[POS_DONE]) begin
      doneFlag_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      doneFlag_r <= RST_CTRL_ONE[POS_DONE];
      sampCnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      doneFlag_r <= doneFlag_nxt;
      sampCnt_r <= (sampleFlag & ~autoDue) ? sampCnt_r + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence count, buffer halves, alternate input

  wire logic [3:0] wrAddr = splitMode_r ? {fillHalf_r, wrIdx_r[2:0]} : wrIdx_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      seqCnt_r <= 4'h0;
      wrIdx_r <= 4'h0;
      fillHalf_r <= 1'b0;
      altB_r <= 1'b0;
    end else if (~onBit_r) begin
      seqCnt_r <= 4'h0;
      wrIdx_r <= 4'h0;
      fillHalf_r <= 1'b0;
      altB_r <= 1'b0;
    end else begin
      if (doneSet) begin
        seqCnt_r <= seqHit ? 4'h0 : seqCnt_r + 4'h1;
        wrIdx_r <= seqHit ? 4'h0 : wrIdx_r + 4'h1;
        altB_r <= altMode_r & ~altB_r;
      end else if (~altMode_r) begin
        altB_r <= 1'b0;
      end
      if (~splitMode_r) begin
        fillHalf_r <= 1'b0;
      end else if (doneSet & seqHit) begin
        fillHalf_r <= ~fillHalf_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one clear

  wire logic [1:0] irqEvent = {doneSet, doneSet & seqHit};
  assign irqStat_nxt = (irqStat_r & ~(wrIrqStat ? pwdata[1:0] : 2'h0)) | irqEvent;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irqStat_r <= RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge core_clk) begin
    if (reset) begin
      convStart_r <= 1'b0;
      sampling_r <= 1'b0;
      refHighExt_r <= 1'b0;
      refLowExt_r <= 1'b0;
      offsetCalOn_r <= 1'b0;
      scanOn_r <= 1'b0;
      muxSelB_r <= 1'b0;
      bufWrEn_r <= 1'b0;
      bufWrAddr_r <= 4'h0;
    end else begin
      convStart_r <= startConv;
      sampling_r <= (state_nxt == ST_SAMPLE);
      refHighExt_r <= ~refSel_r[2] & refSel_r[0];
      refLowExt_r <= ~refSel_r[2] & refSel_r[1];
      offsetCalOn_r <= offset_cal_enable_r;
      scanOn_r <= scanEn_r & onBit_r;
      muxSelB_r <= altB_r;
      bufWrEn_r <= doneSet;
      bufWrAddr_r <= wrAddr;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign convStart = convStart_r;
  assign sampling = sampling_r;
  assign refHighExt = refHighExt_r;
  assign refLowExt = refLowExt_r;
  assign offsetCalOn = offsetCalOn_r;
  assign scanOn = scanOn_r;
  assign muxSelB = muxSelB_r;
  assign bufWrEn = bufWrEn_r;
  assign bufWrAddr = bufWrAddr_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_AUTO_TRIG: assert property (
    onBit_r && sampleFlag && trigSrc_r == TRIG_AUTO && autoDue |=> state_r == ST_CONVERT)
    else $error("auto trigger did not start conversion");

  AST_RESERVED: assert property (
    sampleFlag && trigSrc_r[2] && trigSrc_r != TRIG_AUTO |=> state_r != ST_CONVERT)
    else $error("reserved trigger code started conversion");

  AST_CHARGE: assert property (
    onBit_r && sampleFlag && trigSrc_r == TRIG_CHARGE && chargeTimeTrig |=> convStart_r)
    else $error("charge unit event ignored");

  AST_TIMER: assert property (
    onBit_r && sampleFlag && trigSrc_r == TRIG_TIMER && timerThreeMatch |=> convStart_r)
    else $error("timer match ignored");

  AST_EXT_PIN: assert property (
    onBit_r && sampleFlag && trigSrc_r == TRIG_EXT_PIN && extRise |=> convStart_r ##1 !sampling)
    else $error("pin edge did not end sampling");

  AST_SOFT_ONLY: assert property (
    sampleFlag && trigSrc_r == TRIG_SOFT && !swConv |=> !convStart_r)
    else $error("soft trigger mode converted without a clear");

  AST_DONE_SET: assert property (
    doneSet |=> doneFlag_r && bufWrEn_r)
    else $error("done flag not set at completion");

  AST_DONE_CLR: assert property (
    convStart_r |-> !doneFlag_r)
    else $error("done flag still set at conversion start");

  AST_DISABLED: assert property (
    !onBit_r |=> state_r == ST_IDLE && !convStart_r)
    else $error("converter active while disabled");

  AST_SEQ_IRQ: assert property (
    doneSet && seqHit |=> irqStat_r[POS_IRQ_SEQ] && seqCnt_r == 4'h0)
    else $error("sequence interrupt missed");

  AST_HALF_SWAP: assert property (
    doneSet && seqHit && splitMode_r |=> fillHalf_r != $past(fillHalf_r))
    else $error("fill half did not swap");

endmodule : adcsc_top

`default_nettype wire

// [dv/adcsc_tb.sv]
/*
  Self-checking bench for the converter sequence control block: registers over APB,
  trigger sources, done flag, reference and input selection, sequence count and buffer address.
  Assumes the adcsc_pkg constants and a zero-wait APB slave on core_clk.
*/
`default_nettype none

module testbench
  import adcsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Design ports
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic chargeTimeTrig = 1'b0;
  logic timerThreeMatch = 1'b0;
  logic extIntZeroPin = 1'b0;
  logic convComplete = 1'b0;
  logic convStart, sampling, refHighExt, refLowExt, offsetCalOn, scanOn, muxSelB;
  logic bufWrEn, irq;
  logic [3:0] bufWrAddr;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int starts = 0;
  logic [31:0] rd;
  logic err;

  adcsc_top adcsc_top_inst (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chargeTimeTrig(chargeTimeTrig), .timerThreeMatch(timerThreeMatch),
    .extIntZeroPin(extIntZeroPin), .convComplete(convComplete), .convStart(convStart),
    .sampling(sampling), .refHighExt(refHighExt), .refLowExt(refLowExt),
    .offsetCalOn(offsetCalOn), .scanOn(scanOn), .muxSelB(muxSelB), .bufWrEn(bufWrEn),
    .bufWrAddr(bufWrAddr), .irq(irq)
  );

  always #4 core_clk = ~core_clk;

  // Counts conversion starts and cuts a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (convStart === 1'b1) begin
      starts <= starts + 1;
    end
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks and expectation functions
  task automatic final_report();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check("apb answer", 32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd_reg

  function automatic logic [1:0] ref_exp(input logic [2:0] c);
    return c[2] ? 2'b00 : {c[0], c[1]};
  endfunction : ref_exp

  function automatic logic trig_valid(input logic [2:0] c);
    return (c <= TRIG_CHARGE) || (c == TRIG_AUTO);
  endfunction : trig_valid

  // Fires the source of code c; reserved codes fire the charge, timer and pin sources together
  task automatic fire(input logic [2:0] c);
    if (c == TRIG_SOFT) begin
      wr(OFS_CTRL_ONE, 32'h8000);
    end else begin
      @(posedge core_clk);
      chargeTimeTrig <= (c == TRIG_CHARGE) || c[2];
      timerThreeMatch <= (c == TRIG_TIMER) || c[2];
      extIntZeroPin <= (c == TRIG_EXT_PIN) || c[2];
      @(posedge core_clk);
      chargeTimeTrig <= 1'b0;
      timerThreeMatch <= 1'b0;
      repeat (2) @(posedge core_clk);
      extIntZeroPin <= 1'b0;
    end
  endtask : fire

  task automatic wait_start(input int lim);
    int s0;
    int n;
    s0 = starts;
    for (n = 0; n < lim && starts == s0; n++) @(posedge core_clk);
  endtask : wait_start

  task automatic complete();
    @(posedge core_clk);
    convComplete <= 1'b1;
    @(posedge core_clk);
    convComplete <= 1'b0;
    @(posedge core_clk);
    check("buffer write", 32'(bufWrEn), 32'h1);
  endtask : complete

  task automatic run_conv(input logic [2:0] c);
    int s0;
    wr(OFS_CTRL_ONE, 32'h8001 | (32'(c) << POS_TRIG_LO));
    wr(OFS_CTRL_ONE, 32'h8003 | (32'(c) << POS_TRIG_LO));
    repeat (3) @(posedge core_clk);
    check("sampling", 32'(sampling), 32'h1);
    s0 = starts;
    fire(c);
    wait_start(40);
    check("conversion starts", 32'(starts - s0), 32'(trig_valid(c)));
    if (trig_valid(c)) begin
      rd_reg(OFS_CTRL_ONE);
      check("flags at start", rd & 32'h3, 32'h0);
      complete();
      rd_reg(OFS_CTRL_ONE);
      check("done flag", rd & 32'h3, 32'h1);
    end else begin
      check("sampling held", 32'(sampling), 32'h1);
      wr(OFS_CTRL_ONE, 32'h2);
      repeat (3) @(posedge core_clk);
      check("disabled", 32'(sampling), 32'h0);
    end
  endtask : run_conv

  task automatic seq_run(input logic split, input logic alt, input logic [3:0] nseq);
    int k;
    int n1;
    logic [31:0] expAddr;
    n1 = int'(nseq) + 1;
    wr(OFS_CTRL_TWO, (32'(nseq) << POS_SEQ_LO) | (32'(split) << POS_SPLIT) | 32'(alt));
    wr(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_CTRL_ONE, 32'h8000 | (32'(TRIG_AUTO) << POS_TRIG_LO) | 32'h4);
    for (k = 0; k < 2 * n1; k++) begin
      wait_start(60);
      complete();
      expAddr = split ? 32'({1'((k / n1) % 2), 3'(k % n1)}) : 32'(k % n1);
      check("buffer address", 32'(bufWrAddr), expAddr);
      @(posedge core_clk);
      check("interrupt", 32'(irq), 32'((k + 1) % n1 == 0));
      check("input select", 32'(muxSelB), 32'(alt && (k % 2 == 0)));
      if ((k + 1) % n1 == 0) begin
        rd_reg(OFS_CTRL_TWO);
        if (split) begin
          check("fill status", 32'(rd[POS_FILL_HALF]), 32'((k / n1) % 2 == 0));
        end
        wr(OFS_IRQ_STAT, 32'h1);
      end
    end
    wr(OFS_CTRL_ONE, 32'h0);
  endtask : seq_run

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int i;
    logic [31:0] d;
    void'($urandom(32'h93CCEE9C));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd_reg(8'(i * 4));
      check("reset value", rd, (i == 4) ? 32'(RST_SAMPLE_ACTIVE_FLAG_TIME) : 32'h0);
    end
    rd_reg(8'h14);
    check("unmapped error", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(OFS_CTRL_ONE, 32'h8000);
    for (i = 0; i < 8; i++) begin
      d = (32'(i) << POS_REF_LO) | ($urandom & 32'h00001400);
      wr(OFS_CTRL_TWO, d);
      repeat (2) @(posedge core_clk);
      check("reference", 32'({refHighExt, refLowExt}), 32'(ref_exp(3'(i))));
      check("offset cal", 32'(offsetCalOn), 32'(d[POS_OFFSET_CAL_ENABLE]));
      check("scan", 32'(scanOn), 32'(d[POS_SCAN]));
      rd_reg(OFS_CTRL_TWO);
      check("control two", rd, d);
    end
    wr(OFS_CTRL_ONE, 32'h0);
    repeat (2) @(posedge core_clk);
    check("scan off", 32'(scanOn), 32'h0);
    for (i = 0; i < 8; i++) begin
      run_conv(3'(i));
    end
    seq_run(1'b1, 1'b1, 4'($urandom_range(0, 7)));
    seq_run(1'b0, 1'b0, 4'hF);
    wr(OFS_CTRL_ONE, 32'h0);
    rd_reg(OFS_CTRL_ONE);
    check("done cleared", 32'(rd[POS_DONE]), 32'h0);
    wr(OFS_CTRL_ONE, 32'h1);
    rd_reg(OFS_CTRL_ONE);
    check("done not set", 32'(rd[POS_DONE]), 32'h0);
    check("irq masked", 32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge core_clk);
    check("irq unmasked", 32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge core_clk);
    check("irq cleared", 32'(irq), 32'h0);
    final_report();
  end

endmodule : testbench

`default_nettype wire
